//--- verilog/bgp_cfg.svh
// Register map, reset values and field positions of the GPIO port block
`ifndef BGP_CFG_SVH
`define BGP_CFG_SVH

// Word index of each register; byte address is four times the index
`define BGP_IDX_PORT_H 4'h0
`define BGP_IDX_PORT_J 4'h3
`define BGP_IDX_PORT_K 4'h6
`define BGP_IDX_ANALOG 4'h9
`define BGP_IDX_LAST 4'h9

// Offsets inside a port group of three registers
`define BGP_SUB_DIRECTION 4'h0
`define BGP_SUB_PINS 4'h1
`define BGP_SUB_LATCH 4'h2
`define BGP_PORT_STRIDE 4'h3

// Byte addresses
`define BGP_OFS_PORT_H_DIRECTION 32'h0000_0000
`define BGP_OFS_PORT_H_PINS 32'h0000_0004
`define BGP_OFS_PORT_H_OUTPUT_LATCH 32'h0000_0008
`define BGP_OFS_PORT_J_DIRECTION 32'h0000_000c
`define BGP_OFS_PORT_J_PINS 32'h0000_0010
`define BGP_OFS_PORT_J_OUTPUT_LATCH 32'h0000_0014
`define BGP_OFS_PORT_K_DIRECTION 32'h0000_0018
`define BGP_OFS_PORT_K_PINS 32'h0000_001c
`define BGP_OFS_PORT_K_OUTPUT_LATCH 32'h0000_0020
`define BGP_OFS_ANALOG_PIN_CONFIG 32'h0000_0024

// Reset values
`define BGP_DIRECTION_RST 8'hff
`define BGP_LATCH_RST 8'h00
`define BGP_ANALOG_RST 8'h00

// analog_pin_config fields: pin_config_sel in 3:0, vref_config_sel in 5:4
`define BGP_ANALOG_WMASK 8'h3f
`define BGP_PIN_CFG_LSB 0
`define BGP_PIN_CFG_MSB 3
`define BGP_PIN_CFG_ALL_DIGITAL 4'hf
`define BGP_SHARED_LSB 4

`endif

//--- verilog/bgp_pkg.sv
// Types shared by the GPIO port block
package bgp_pkg;
  typedef logic [7:0] bgp_byte_t;
  typedef logic [3:0] bgp_idx_t;
  typedef logic [3:0] bgp_nibble_t;
endpackage

//--- verilog/bgp_gpio.sv
// Three bidirectional 8-bit GPIO ports with an AHB-Lite register slave
// What this block does
// - A direction bit of 1 turns the pin's driver off so the pin is an input.
// - A direction bit of 0 makes the pin an output driving its latch bit.
// - Reading the output latch returns the latch, not the pin; writing it loads the latch.
// - Reading the pins register returns pin levels; writing it loads the output latch.
// - Every kind of reset sets all direction bits to one.
// - Latches start at zero on power-on and keep their value on other resets.
// - Upper four pins of the first port double as analog channels twelve to fifteen.
// - The second and third ports are eight bits, each pin set independently.
// - After power-on the shared pins are analog and read as zero.
`include "bgp_cfg.svh"

module bgp_gpio (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic other_reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire bgp_pkg::bgp_byte_t port_h_in,
  output bgp_pkg::bgp_byte_t port_h_out,
  output bgp_pkg::bgp_byte_t port_h_oe,
  input wire bgp_pkg::bgp_byte_t port_j_in,
  output bgp_pkg::bgp_byte_t port_j_out,
  output bgp_pkg::bgp_byte_t port_j_oe,
  input wire bgp_pkg::bgp_byte_t port_k_in,
  output bgp_pkg::bgp_byte_t port_k_out,
  output bgp_pkg::bgp_byte_t port_k_oe,
  output bgp_pkg::bgp_nibble_t analog_shared_pins
);
  import bgp_pkg::*;

  localparam int NPORTS = 3;

  // Bus side
  logic addr_phase;
  logic addr_mapped;
  bgp_idx_t addr_idx;
  logic wr_pend;
  bgp_idx_t wr_idx;
  bgp_byte_t wdata;
  bgp_byte_t rd_byte;

  // Analog sharing of the first port
  bgp_byte_t analog_cfg;
  bgp_byte_t next_analog_cfg;
  bgp_nibble_t next_shared;

  // Per-port views joined from the generate loop
  bgp_byte_t pin_in_w [NPORTS];
  bgp_byte_t rd_part [NPORTS];
  bgp_byte_t out_w [NPORTS];
  bgp_byte_t oe_w [NPORTS];
  bgp_byte_t read_mask [NPORTS];

  assign addr_phase = hsel && htrans[1] && hready;
  assign addr_idx = haddr[5:2];
  assign addr_mapped = (haddr[31:6] == 26'h000_0000) && (addr_idx <= `BGP_IDX_LAST);
  assign wdata = hwdata[7:0];

  // Data phase of a write; the registers load on the edge that ends it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx <= 4'h0;
    end else begin
      wr_pend <= addr_phase && hwrite && addr_mapped;
      wr_idx <= addr_idx;
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Direction, latch and analog reads are taken from next-state values so a read
  // right behind a write to the same register already sees the written byte.
  always_comb begin
    rd_byte = rd_part[0] | rd_part[1] | rd_part[2];
    if (addr_idx == `BGP_IDX_ANALOG) begin
      rd_byte = next_analog_cfg;
    end
    if (!addr_mapped) begin
      rd_byte = 8'h00;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      hrdata <= {24'h00_0000, rd_byte};
    end
  end

  // Analog pin configuration; bits 7:6 do not exist and read zero
  always_comb begin
    next_analog_cfg = analog_cfg;
    if (other_reset) begin
      next_analog_cfg = `BGP_ANALOG_RST;
    end else if (wr_pend && wr_idx == `BGP_IDX_ANALOG) begin
      next_analog_cfg = wdata & `BGP_ANALOG_WMASK;
    end
  end

  // Until software selects all-digital, the shared pins stay analog
  always_comb begin
    next_shared = 4'hf;
    if (next_analog_cfg[`BGP_PIN_CFG_MSB:`BGP_PIN_CFG_LSB] == `BGP_PIN_CFG_ALL_DIGITAL) begin
      next_shared = 4'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      analog_cfg <= `BGP_ANALOG_RST;
      analog_shared_pins <= 4'hf;
    end else begin
      analog_cfg <= next_analog_cfg;
      analog_shared_pins <= next_shared;
    end
  end

  assign pin_in_w[0] = port_h_in;
  assign pin_in_w[1] = port_j_in;
  assign pin_in_w[2] = port_k_in;

  // Analog pins read as zero through the pins register
  assign read_mask[0] = {~analog_shared_pins, 4'hf};
  assign read_mask[1] = 8'hff;
  assign read_mask[2] = 8'hff;

  // One identical port per iteration; every bit is independent
  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    localparam bgp_idx_t BASE = 4'(p * 3);
    bgp_byte_t direction;
    bgp_byte_t latch;
    bgp_byte_t oe;
    bgp_byte_t next_direction;
    bgp_byte_t next_latch;
    bgp_byte_t sync_a;
    bgp_byte_t sync_b;

    always_comb begin
      next_direction = direction;
      if (other_reset) begin
        next_direction = `BGP_DIRECTION_RST;
      end else if (wr_pend && wr_idx == BASE + `BGP_SUB_DIRECTION) begin
        next_direction = wdata;
      end
    end

    // Latch survives other_reset; pins and latch writes both load it
    always_comb begin
      next_latch = latch;
      if (wr_pend && (wr_idx == BASE + `BGP_SUB_PINS)) begin
        next_latch = wdata;
      end else if (wr_pend && (wr_idx == BASE + `BGP_SUB_LATCH)) begin
        next_latch = wdata;
      end
    end

    // Enable kept as its own flop so the pin driver is never combinational
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        direction <= `BGP_DIRECTION_RST;
        oe <= 8'h00;
      end else begin
        direction <= next_direction;
        oe <= ~next_direction;
      end
    end

    // Power-on value is undefined; zero chosen so the pads are known
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        latch <= `BGP_LATCH_RST;
      end else begin
        latch <= next_latch;
      end
    end

    // Two-stage synchroniser; only sync_b is read by logic
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        sync_a <= 8'h00;
        sync_b <= 8'h00;
      end else begin
        sync_a <= pin_in_w[p];
        sync_b <= sync_a;
      end
    end

    always_comb begin
      rd_part[p] = 8'h00;
      if (addr_idx == BASE + `BGP_SUB_DIRECTION) begin
        rd_part[p] = next_direction;
      end else if (addr_idx == BASE + `BGP_SUB_PINS) begin
        rd_part[p] = sync_b & read_mask[p];
      end else if (addr_idx == BASE + `BGP_SUB_LATCH) begin
        rd_part[p] = next_latch;
      end
    end

    assign out_w[p] = latch;
    assign oe_w[p] = oe;
  end

  assign port_h_out = out_w[0];
  assign port_h_oe = oe_w[0];
  assign port_j_out = out_w[1];
  assign port_j_oe = oe_w[1];
  assign port_k_out = out_w[2];
  assign port_k_oe = oe_w[2];

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_write(bgp_idx_t idx);
    wr_pend && wr_idx == idx && !other_reset;
  endsequence

  sequence s_read(logic [31:0] ofs);
    addr_phase && !hwrite && haddr == ofs;
  endsequence

  a_dir_drives_oe: assert property (
    s_write(`BGP_IDX_PORT_H + `BGP_SUB_DIRECTION) |=> port_h_oe == ~$past(hwdata[7:0]))
    else $error("Direction write did not set the port h enables");

  a_latch_to_pin: assert property (
    s_write(`BGP_IDX_PORT_J + `BGP_SUB_LATCH) |=> port_j_out == $past(hwdata[7:0]))
    else $error("Latch write did not reach the port j pins");

  a_pins_write_latch: assert property (
    s_write(`BGP_IDX_PORT_K + `BGP_SUB_PINS) |=> port_k_out == $past(hwdata[7:0]))
    else $error("Pins write did not load the port k latch");

  a_latch_read_back: assert property (
    (s_read(`BGP_OFS_PORT_H_OUTPUT_LATCH) and !wr_pend)
      |=> hrdata == {24'h00_0000, port_h_out})
    else $error("Latch read did not return the latch");

  a_pin_read_sync: assert property (
    (s_read(`BGP_OFS_PORT_J_PINS) and $stable(port_j_in) && port_j_in == $past(port_j_in, 2))
      |=> hrdata[7:0] == $past(port_j_in))
    else $error("Pins read did not return the synchronised level");

  a_other_reset_dir: assert property (
    // A write landing right after the reset is legal and may drive again
    other_reset ##1 (other_reset || !wr_pend)
      |-> (port_h_oe | port_j_oe | port_k_oe) == 8'h00
      ##1 (port_h_oe | port_j_oe | port_k_oe) == 8'h00)
    else $error("Other reset left a pin driving");

  a_latch_kept: assert property (
    other_reset && !wr_pend |=> $stable(port_h_out) && $stable(port_j_out) && $stable(port_k_out))
    else $error("Other reset disturbed a latch");

  a_analog_reads_zero: assert property (
    (s_read(`BGP_OFS_PORT_H_PINS) and !wr_pend && analog_shared_pins == 4'hf)
      |=> hrdata[7:4] == 4'h0)
    else $error("Analog pin did not read as zero");

  a_shared_select: assert property (
    (s_write(`BGP_IDX_ANALOG) and hwdata[3:0] == 4'hf) |=> analog_shared_pins == 4'h0)
    else $error("All-digital selection did not free the shared pins");

  a_single_edge: assert property (
    addr_phase && hwrite && haddr == `BGP_OFS_PORT_K_DIRECTION && !other_reset
      ##1 !other_reset |=> port_k_oe == ~$past(hwdata[7:0]) && hreadyout)
    else $error("Write did not land on the edge ending its data phase");

  // Several-step behaviours: a stray write, and a reset followed by a read
  sequence s_stray_write;
    addr_phase && hwrite && !addr_mapped ##1 !other_reset;
  endsequence

  sequence s_reset_then_read(logic [31:0] ofs);
    other_reset ##1 (!other_reset && !wr_pend)
      ##1 (s_read(ofs) and !other_reset && !wr_pend);
  endsequence

  a_stray_write: assert property (
    s_stray_write |=> $stable(port_h_oe) && $stable(port_j_oe) && $stable(port_k_oe)
      && $stable(port_h_out) && $stable(port_j_out) && $stable(port_k_out)
      && $stable(analog_shared_pins))
    else $error("Write to an unmapped address changed a register");

  a_soft_reset_read: assert property (
    s_reset_then_read(`BGP_OFS_PORT_J_DIRECTION) |=> hrdata[7:0] == `BGP_DIRECTION_RST)
    else $error("Direction did not read all ones right after a reset");

  a_reset_analog: assert property (
    other_reset |=> analog_shared_pins == 4'hf)
    else $error("Reset did not return the shared pins to analog");

  a_analog_kept: assert property (
    (s_write(`BGP_IDX_ANALOG) and hwdata[3:0] != 4'hf) |=> analog_shared_pins == 4'hf)
    else $error("Partial digital selection freed the shared pins");

  a_latch_h_write: assert property (
    s_write(`BGP_IDX_PORT_H + `BGP_SUB_LATCH) |=> port_h_out == $past(hwdata[7:0]))
    else $error("Latch write did not load the port h latch");

  a_latch_read_k: assert property (
    (s_read(`BGP_OFS_PORT_K_OUTPUT_LATCH) and !wr_pend) |=> hrdata == {24'h00_0000, port_k_out})
    else $error("Latch read did not return the port k latch");

  a_oe_j_write: assert property (
    s_write(`BGP_IDX_PORT_J + `BGP_SUB_DIRECTION) |=> port_j_oe == ~$past(hwdata[7:0]))
    else $error("Direction write did not set the port j enables");

  a_pin_read_h: assert property (
    (s_read(`BGP_OFS_PORT_H_PINS) and analog_shared_pins == 4'h0 && $stable(port_h_in)
      && port_h_in == $past(port_h_in, 2)) |=> hrdata[7:0] == $past(port_h_in))
    else $error("Pins read on port h did not return the synchronised level");

  a_unmapped_zero: assert property (
    addr_phase && !hwrite && !addr_mapped |=> hrdata == 32'h0000_0000)
    else $error("Read of an unmapped address returned data");

  a_analog_cfg_read: assert property (
    (s_read(`BGP_OFS_ANALOG_PIN_CONFIG) and !wr_pend) |=> hrdata[7:6] == 2'b00)
    else $error("Missing configuration bits did not read zero");

  a_oe_hold: assert property (
    !wr_pend && !other_reset |=> $stable(port_h_oe) && $stable(port_j_oe) && $stable(port_k_oe))
    else $error("A pin enable changed without a write or reset");

  a_latch_hold: assert property (
    !wr_pend |=> $stable(port_h_out) && $stable(port_j_out) && $stable(port_k_out))
    else $error("A latch changed without a write");

endmodule

//--- verification/bgp_pin_model.sv
// Board side of one eight-bit port: pin drivers, outside sources, pull-ups
module bgp_pin_model (
  input wire logic [7:0] out,
  input wire logic [7:0] oe,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  output logic [7:0] level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Undriven pins go to the pull-up, never to a stale value
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      level[i] = oe[i] ? out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule

//--- verification/tb_top.sv
// Self-checking bench for the three-port GPIO block
`include "bgp_cfg.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk;
  logic hresetn;
  logic other_reset;
  logic hsel;
  logic hwrite;
  logic hready;
  logic hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [7:0] h_in, h_out, h_oe, j_in, j_out, j_oe, k_in, k_out, k_oe, xv, xe;
  logic [3:0] shared;
  int failures;
  int checked;
  bgp_gpio uut (.hclk(hclk), .hresetn(hresetn), .other_reset(other_reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hwdata(hwdata), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .port_h_in(h_in), .port_h_out(h_out), .port_h_oe(h_oe),
    .port_j_in(j_in), .port_j_out(j_out), .port_j_oe(j_oe),
    .port_k_in(k_in), .port_k_out(k_out), .port_k_oe(k_oe),
    .analog_shared_pins(shared));
  bgp_pin_model ph (.out(h_out), .oe(h_oe), .ext_val(xv), .ext_en(xe), .level(h_in));
  bgp_pin_model pj (.out(j_out), .oe(j_oe), .ext_val(xv), .ext_en(xe), .level(j_in));
  bgp_pin_model pk (.out(k_out), .oe(k_oe), .ext_val(xv), .ext_en(xe), .level(k_in));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  // One single transfer; read data is taken at the edge ending the data phase
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    #1;
  endtask
  task rdchk(input string n, input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(n, rd, e);
  endtask
  task t_reset;
    rdchk("h dir", `BGP_OFS_PORT_H_DIRECTION, 32'h0000_00ff);
    rdchk("k dir", `BGP_OFS_PORT_K_DIRECTION, 32'h0000_00ff);
    rdchk("h latch", `BGP_OFS_PORT_H_OUTPUT_LATCH, 32'h0000_0000);
    chk("oe", 32'({h_oe, j_oe, k_oe}), 32'h0000_0000);
    chk("shared", 32'(shared), 32'h0000_000f);
    rdchk("h pins", `BGP_OFS_PORT_H_PINS, 32'h0000_000a);
  endtask
  task t_drive;
    xfer(1'b1, `BGP_OFS_PORT_J_OUTPUT_LATCH, 32'h0000_00a5);
    xfer(1'b1, `BGP_OFS_PORT_J_DIRECTION, 32'h0000_000f);
    chk("j oe", 32'(j_oe), 32'h0000_00f0);
    chk("j out", 32'(j_out), 32'h0000_00a5);
    repeat (3) @(posedge hclk);
    rdchk("j pins", `BGP_OFS_PORT_J_PINS, 32'h0000_00aa);
    rdchk("j latch", `BGP_OFS_PORT_J_OUTPUT_LATCH, 32'h0000_00a5);
    xfer(1'b1, `BGP_OFS_PORT_K_PINS, 32'h0000_ff3c);
    rdchk("k latch", `BGP_OFS_PORT_K_OUTPUT_LATCH, 32'h0000_003c);
    chk("k out", 32'(k_out), 32'h0000_003c);
  endtask
  task t_analog;
    xfer(1'b1, `BGP_OFS_ANALOG_PIN_CONFIG, 32'h0000_00ff);
    rdchk("cfg", `BGP_OFS_ANALOG_PIN_CONFIG, 32'h0000_003f);
    chk("shared", 32'(shared), 32'h0000_0000);
    xfer(1'b1, `BGP_OFS_PORT_H_OUTPUT_LATCH, 32'h0000_0030);
    xfer(1'b1, `BGP_OFS_PORT_H_DIRECTION, 32'h0000_00cf);
    repeat (3) @(posedge hclk);
    rdchk("h pins", `BGP_OFS_PORT_H_PINS, 32'h0000_007a);
    // Any selection short of all-digital puts the shared pins back to analog
    xfer(1'b1, `BGP_OFS_ANALOG_PIN_CONFIG, 32'h0000_000e);
    chk("shared", 32'(shared), 32'h0000_000f);
    rdchk("h pins", `BGP_OFS_PORT_H_PINS, 32'h0000_000a);
  endtask
  task t_other;
    @(posedge hclk);
    other_reset <= 1'b1;
    @(posedge hclk);
    other_reset <= 1'b0;
    rdchk("j dir", `BGP_OFS_PORT_J_DIRECTION, 32'h0000_00ff);
    rdchk("j latch", `BGP_OFS_PORT_J_OUTPUT_LATCH, 32'h0000_00a5);
    chk("j oe", 32'(j_oe), 32'h0000_0000);
    chk("shared", 32'(shared), 32'h0000_000f);
  endtask
  task t_unmapped;
    xfer(1'b1, `BGP_OFS_PORT_K_DIRECTION, 32'h0000_00c3);
    chk("k oe", 32'(k_oe), 32'h0000_003c);
    xfer(1'b1, 32'h0000_0028, 32'h0000_00ff);
    // Same low bits as the first register; must not alias onto it
    xfer(1'b1, 32'h0000_0040, 32'h0000_0000);
    rdchk("h dir", `BGP_OFS_PORT_H_DIRECTION, 32'h0000_00ff);
    rdchk("k dir", `BGP_OFS_PORT_K_DIRECTION, 32'h0000_00c3);
    rdchk("unmapped", 32'h0000_0028, 32'h0000_0000);
    chk("hresp", 32'(hresp), 32'h0000_0000);
  endtask
  task test_done;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge hclk);
    failures++;
    test_done;
  end
  initial begin
    failures = 0;
    checked = 0;
    hresetn = 1'b0;
    other_reset = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    xv = 8'h5a;
    xe = 8'hff;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_drive;
    t_analog;
    t_other;
    t_unmapped;
    test_done;
  end
endmodule
